// ==== src/ssc_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module ssc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   input wire logic clear,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [PW:0] cnt;
   } ssc_fifo_st_t;

   ssc_fifo_st_t st_reg;
   ssc_fifo_st_t st_next;
   logic push;
   logic pop;

   assign in_ready = st_reg.cnt != (PW + 1)'(DEPTH);
   assign out_valid = st_reg.cnt != '0;
   assign out_data = st_reg.mem[st_reg.rp];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb
   begin
      st_next = st_reg;
      if (push)
      begin
         st_next.mem[st_reg.wp] = in_data;
         st_next.wp = st_reg.wp + 1'b1;
      end
      if (pop)
      begin
         st_next.rp = st_reg.rp + 1'b1;
      end
      st_next.cnt = st_reg.cnt + (PW + 1)'(push) - (PW + 1)'(pop);
      if (clear)
      begin
         st_next.wp = '0;
         st_next.rp = '0;
         st_next.cnt = '0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

endmodule : ssc_fifo
`default_nettype wire

// ==== src/ssc_pkg.sv ====
package ssc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Word and sample sizes
   localparam int WORD_BITS = 32;
   localparam int SRC_BITS = 24;
   localparam int NUM_SLOTS = 16;
   localparam logic [5:0] WORD_BITS_CNT = 6'h20;

   ////////////////////////////////////////////////////////////////////////////
   // Serial slave framing
   localparam logic [4:0] HDR_END = 5'h18;
   localparam logic [4:0] HDR_LAST = 5'h17;
   localparam int RW_POS = 0;
   localparam logic [15:0] BURST_FIRST = 16'he50c;
   localparam logic [15:0] BURST_LAST = 16'he51b;
   localparam logic [15:0] ADDR_STEP = 16'h0001;
   localparam logic [1:0] LEN_8 = 2'h0;
   localparam logic [1:0] LEN_16 = 2'h1;
   localparam logic [1:0] LEN_32 = 2'h2;
   localparam logic [5:0] BITS_8 = 6'h08;
   localparam logic [5:0] BITS_16 = 6'h10;

   ////////////////////////////////////////////////////////////////////////////
   // Capture port configuration
   localparam int CAP_EN_POS = 6;
   localparam int CFG_RATE_POS = 0;
   localparam int CFG_SIZE_POS = 1;
   localparam int CFG_GAP_POS = 2;
   localparam int CFG_XFER_LO = 3;
   localparam int CFG_POL_POS = 5;
   localparam logic [1:0] XFER_WAVE = 2'h1;
   localparam logic [1:0] XFER_POWER = 2'h2;
   localparam logic [3:0] SLOT_FIRST_ALL = 4'h0;
   localparam logic [3:0] SLOT_FIRST_POWER = 4'h7;
   localparam logic [4:0] COUNT_ALL = 5'h10;
   localparam logic [4:0] COUNT_WAVE = 5'h07;
   localparam logic [4:0] COUNT_POWER = 5'h09;
   localparam logic [3:0] SLOT_NEUTRAL = 4'h6;
   localparam logic [3:0] SLOT_REACTIVE = 4'hd;
   localparam logic [2:0] GAP_CYCLES = 3'h7;

   ////////////////////////////////////////////////////////////////////////////
   // Capture clock from the 100 MHz clock, in half nanoseconds
   localparam int CLK_MHZ = 100;
   localparam int CAP_FAST_MHZ = 8;
   localparam int CAP_SLOW_MHZ = 4;
   localparam logic [8:0] CLK_HNS = 9'(2000 / CLK_MHZ);
   localparam logic [8:0] HALF_FAST_HNS = 9'(1000 / CAP_FAST_MHZ);
   localparam logic [8:0] HALF_SLOW_HNS = 9'(1000 / CAP_SLOW_MHZ);

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic [1:0] reserved;
      logic select_polarity;
      logic [1:0] word_set_select;
      logic interword_gap_enable;
      logic size_8bit;
      logic rate_slow;
   } ssc_cap_cfg_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [31:0] data;
      logic [1:0] len;
   } ssc_wr_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [31:0] data;
   } ssc_rd_t;

   function automatic logic [WORD_BITS-1:0] sext(input logic [SRC_BITS-1:0] v);
      sext = {{(WORD_BITS - SRC_BITS){v[SRC_BITS-1]}}, v};
   endfunction : sext

endpackage : ssc_pkg

// ==== src/ssc_port.sv ====
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Host changes data on falling clock; device samples on rising clock.
// - Upper seven command bits are ignored by the device.
// - Command bit 0 picks write (0) or read (1).
// - Write ends with select and clock high; device lines go high impedance.
// - Read data starts on the falling edge after the last address bit.
// - After the last read bit the host ends; data out goes high impedance.
// - Burst reads cover 0xE50C to 0xE51B, each a 32-bit word.
// - In burst the next address follows at once until select rises or 0xE51B has been sent.
// - Capture port is off after reset until enable bit 6 is set.
// - Capture runs only with the two-wire port selected, not serial slave.
// - Capture sends up to sixteen 32-bit words in fixed slot order.
// - Each 24-bit source sample is sign-extended to 32 bits.
// - Variants lacking neutral or reactive send all-zero words there.
// - Capture port is master: drives its clock, select and data.
// - Capture select stays active for the whole of each 32- or 8-bit package.
// - Rate bit picks 8 MHz or 4 MHz; bits launch on falling edges.
// - Gap bit inserts seven idle clocks between 32- or 8-bit packages.
// - Word set: 00 all, 01 seven waves, 10 nine powers, 11 as 00.
// - Polarity 0 makes select active low; 1 active high; inactive in gaps.
module ssc_port
   import ssc_pkg::*;
#(
   parameter bit HAS_NEUTRAL = 1'b1,
   parameter bit HAS_REACTIVE = 1'b1
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Serial slave pins
   input wire logic sclk_pin,
   input wire logic ss_n_pin,
   input wire logic mosi_pin,
   output logic miso_out,
   output logic miso_oe,
   // Register access toward the core
   output logic reg_wr_strobe,
   output ssc_wr_t reg_wr,
   output logic reg_rd_req,
   output logic [15:0] reg_rd_addr,
   input wire logic [WORD_BITS-1:0] reg_rd_data,
   input wire logic [1:0] reg_rd_len,
   // Sample snapshot from the core
   input wire logic sample_wr_en,
   input wire logic [3:0] sample_wr_slot,
   input wire logic [SRC_BITS-1:0] sample_wr_value,
   input wire logic frame_strobe,
   // Port selection and configuration
   input wire logic spi_selected,
   input wire logic [7:0] device_config,
   input wire ssc_cap_cfg_t capture_configuration_reg,
   // Capture stream port
   output logic capture_serial_clock,
   output logic capture_word_select,
   output logic capture_serial_out,
   output logic capture_busy
);

   typedef enum logic [3:0] {
      CAP_IDLE = 4'b0001,
      CAP_START = 4'b0010,
      CAP_SHIFT = 4'b0100,
      CAP_GAP = 4'b1000
   } ssc_cap_state_t;

   typedef struct packed {
      logic [2:0] sclk_s;
      logic [2:0] ss_s;
      logic [1:0] mosi_s;
      logic [4:0] hdr_cnt;
      logic [23:0] hdr;
      logic [WORD_BITS-1:0] wdata;
      logic [5:0] wcnt;
      logic rd_active;
      logic burst;
      logic tx_wait;
      logic tx_from_mem;
      logic [15:0] cur_addr;
      logic [WORD_BITS-1:0] tx;
      logic [5:0] tx_cnt;
      logic miso;
      logic miso_oe;
      logic wr_strobe;
      ssc_wr_t wr;
      logic rd_req;
      ssc_cap_state_t cstate;
      logic cclk;
      logic [8:0] acc;
      logic [WORD_BITS-1:0] shreg;
      logic [5:0] sent;
      logic [2:0] gap_cnt;
      logic [4:0] words_left;
      logic [3:0] fetch_slot;
      logic [4:0] fetch_left;
      logic fetch_pend;
      logic [3:0] pend_slot;
      logic ws;
      logic sout;
   } ssc_port_st_t;

   ssc_port_st_t st_reg;
   ssc_port_st_t st_next;
   ssc_port_st_t s;
   logic [3:0] mem_slot;
   logic [WORD_BITS-1:0] mem_rdata;
   logic fifo_in_ready;
   logic [WORD_BITS-1:0] fifo_in_data;
   logic fifo_out_valid;
   logic fifo_pop;
   logic [WORD_BITS-1:0] fifo_out_data;
   logic fifo_clear;

   assign s = st_reg;

   function automatic logic in_burst(input logic [15:0] a);
      in_burst = (a >= BURST_FIRST) && (a <= BURST_LAST);
   endfunction : in_burst

   function automatic logic [WORD_BITS-1:0] left_just(input logic [WORD_BITS-1:0] d,
                                                      input logic [1:0] len);
      unique case (len)
         LEN_8: left_just = {d[7:0], 24'h000000};
         LEN_16: left_just = {d[15:0], 16'h0000};
         default: left_just = d;
      endcase
   endfunction : left_just

   ////////////////////////////////////////////////////////////////////////////
   // Snapshot memory and stream buffer
   ssc_sample_mem u_mem (
      .clock(clock),
      .rst(rst),
      .wr_en(sample_wr_en),
      .wr_slot(sample_wr_slot),
      .wr_data(sext(sample_wr_value)),
      .rd_slot(mem_slot),
      .rd_data(mem_rdata)
   );

   ssc_fifo #(
      .WIDTH(WORD_BITS),
      .DEPTH(4)
   ) u_fifo (
      .clock(clock),
      .rst(rst),
      .clear(fifo_clear),
      .in_valid(s.fetch_pend),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data)
   );

   // Missing channels enter the capture buffer as zero; serial burst reads are not masked
   assign fifo_in_data = ((!HAS_NEUTRAL && s.pend_slot == SLOT_NEUTRAL) ||
                          (!HAS_REACTIVE && s.pend_slot >= SLOT_REACTIVE)) ?
                         '0 : mem_rdata;

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      logic sclk_rise;
      logic sclk_fall;
      logic ss_high;
      logic [23:0] hdr_full;
      logic [15:0] next_addr;
      logic [5:0] tx_cnt_inc;
      logic cap_on;
      logic [8:0] acc_sum;
      logic [8:0] half;
      logic cap_fall;
      logic do_load;
      logic do_send;
      logic ws_active;
      logic pkg_end;
      ssc_cap_cfg_t cfg;
      sclk_rise = 1'b0;
      sclk_fall = 1'b0;
      ss_high = 1'b0;
      hdr_full = '0;
      next_addr = '0;
      tx_cnt_inc = '0;
      cap_on = 1'b0;
      acc_sum = '0;
      half = '0;
      cap_fall = 1'b0;
      do_load = 1'b0;
      do_send = 1'b0;
      ws_active = 1'b0;
      pkg_end = 1'b0;
      cfg = capture_configuration_reg;
      st_next = st_reg;
      fifo_pop = 1'b0;
      fifo_clear = 1'b0;

      // Pin synchronisers, edges from second and third stage only
      st_next.sclk_s = {s.sclk_s[1:0], sclk_pin};
      st_next.ss_s = {s.ss_s[1:0], ss_n_pin};
      st_next.mosi_s = {s.mosi_s[0], mosi_pin};
      sclk_rise = s.sclk_s[1] & ~s.sclk_s[2];
      sclk_fall = ~s.sclk_s[1] & s.sclk_s[2];
      ss_high = s.ss_s[1];
      hdr_full = {s.hdr[22:0], s.mosi_s[1]};
      next_addr = s.cur_addr + ADDR_STEP;
      tx_cnt_inc = s.tx_cnt + 1'b1;
      st_next.wr_strobe = 1'b0;
      st_next.rd_req = 1'b0;

      //////////////////////////////////////////////////////////////////////////
      // Serial slave
      if (ss_high)
      begin
         // Completed write is handed over as select rises
         if (!s.ss_s[2] && s.hdr_cnt == HDR_END && !s.hdr[16 + RW_POS] &&
             (s.wcnt == BITS_8 || s.wcnt == BITS_16 || s.wcnt == WORD_BITS_CNT))
         begin
            st_next.wr_strobe = 1'b1;
            st_next.wr.addr = s.hdr[15:0];
            st_next.wr.data = s.wdata;
            st_next.wr.len = (s.wcnt == BITS_8) ? LEN_8 :
                             (s.wcnt == BITS_16) ? LEN_16 : LEN_32;
         end
         st_next.hdr_cnt = '0;
         st_next.wcnt = '0;
         st_next.wdata = '0;
         st_next.rd_active = 1'b0;
         st_next.burst = 1'b0;
         st_next.tx_wait = 1'b0;
         st_next.tx_cnt = '0;
         st_next.miso_oe = 1'b0;
      end
      else
      begin
         if (sclk_rise)
         begin
            if (s.hdr_cnt != HDR_END)
            begin
               st_next.hdr = hdr_full;
               st_next.hdr_cnt = s.hdr_cnt + 1'b1;
               // Only bit 0 of the command is decoded
               if (s.hdr_cnt == HDR_LAST && hdr_full[16 + RW_POS])
               begin
                  st_next.rd_active = 1'b1;
                  st_next.cur_addr = hdr_full[15:0];
                  st_next.burst = in_burst(hdr_full[15:0]);
                  st_next.tx_from_mem = in_burst(hdr_full[15:0]);
                  st_next.tx_wait = 1'b1;
                  st_next.rd_req = ~in_burst(hdr_full[15:0]);
                  st_next.tx = '0;
               end
            end
            else if (!s.hdr[16 + RW_POS])
            begin
               st_next.wdata = {s.wdata[WORD_BITS-2:0], s.mosi_s[1]};
               if (s.wcnt != '1)
                  st_next.wcnt = s.wcnt + 1'b1;
            end
         end
         if (s.tx_wait)
         begin
            st_next.tx_wait = 1'b0;
            st_next.tx = s.tx_from_mem ? mem_rdata : left_just(reg_rd_data, reg_rd_len);
            st_next.tx_cnt = '0;
         end
         else if (sclk_fall && s.rd_active && s.hdr_cnt == HDR_END)
         begin
            st_next.miso_oe = 1'b1;
            st_next.miso = s.tx[WORD_BITS-1];
            st_next.tx = {s.tx[WORD_BITS-2:0], 1'b0};
            st_next.tx_cnt = tx_cnt_inc;
            // Next word fetched right after the last bit of this one
            if (s.burst && tx_cnt_inc == WORD_BITS_CNT && in_burst(next_addr))
            begin
               st_next.cur_addr = next_addr;
               st_next.tx_from_mem = 1'b1;
               st_next.tx_wait = 1'b1;
            end
         end
      end

      // Slot of the address being set up, data ready next cycle
      mem_slot = st_next.cur_addr[3:0] - BURST_FIRST[3:0];
      //////////////////////////////////////////////////////////////////////////
      // Capture clock generator
      cap_on = device_config[CAP_EN_POS] & ~spi_selected;
      half = cfg.rate_slow ? HALF_SLOW_HNS : HALF_FAST_HNS;
      acc_sum = s.acc + CLK_HNS;
      if (s.cstate != CAP_IDLE || !s.cclk)
      begin
         if (acc_sum >= half)
         begin
            st_next.acc = acc_sum - half;
            st_next.cclk = ~s.cclk;
            cap_fall = s.cclk;
         end
         else
            st_next.acc = acc_sum;
      end
      else
         st_next.acc = '0;

      //////////////////////////////////////////////////////////////////////////
      // Fetch words from the snapshot into the buffer
      st_next.fetch_pend = 1'b0;
      if (s.cstate != CAP_IDLE && s.fetch_left != '0 && !s.fetch_pend && fifo_in_ready)
      begin
         mem_slot = s.fetch_slot;
         st_next.fetch_pend = 1'b1;
         st_next.pend_slot = s.fetch_slot;
         st_next.fetch_slot = s.fetch_slot + 1'b1;
         st_next.fetch_left = s.fetch_left - 1'b1;
      end

      //////////////////////////////////////////////////////////////////////////
      // Capture sequencer
      ws_active = cfg.select_polarity;
      pkg_end = (s.sent == WORD_BITS_CNT) || (cfg.size_8bit && s.sent[2:0] == 3'h0);
      unique case (s.cstate)
         CAP_IDLE:
         begin
            st_next.ws = ~ws_active;
            st_next.sout = 1'b1;
            if (cap_on && frame_strobe)
            begin
               st_next.cstate = CAP_START;
               unique case (cfg.word_set_select)
                  XFER_WAVE:
                  begin
                     st_next.fetch_slot = SLOT_FIRST_ALL;
                     st_next.fetch_left = COUNT_WAVE;
                  end
                  XFER_POWER:
                  begin
                     st_next.fetch_slot = SLOT_FIRST_POWER;
                     st_next.fetch_left = COUNT_POWER;
                  end
                  default:
                  begin
                     st_next.fetch_slot = SLOT_FIRST_ALL;
                     st_next.fetch_left = COUNT_ALL;
                  end
               endcase
               st_next.words_left = st_next.fetch_left;
            end
         end
         CAP_START:
         begin
            if (cap_fall && fifo_out_valid)
               do_load = 1'b1;
         end
         CAP_SHIFT:
         begin
            if (cap_fall)
            begin
               if (cfg.interword_gap_enable && pkg_end &&
                   !(s.sent == WORD_BITS_CNT && s.words_left == '0))
               begin
                  st_next.cstate = CAP_GAP;
                  st_next.gap_cnt = GAP_CYCLES - 1'b1;
                  st_next.ws = ~ws_active;
               end
               else if (s.sent == WORD_BITS_CNT)
               begin
                  if (s.words_left == '0)
                  begin
                     st_next.cstate = CAP_IDLE;
                     st_next.ws = ~ws_active;
                     st_next.sout = 1'b1;
                  end
                  else if (fifo_out_valid)
                     do_load = 1'b1;
                  else
                  begin
                     st_next.cstate = CAP_START;
                     st_next.ws = ~ws_active;
                  end
               end
               else
                  do_send = 1'b1;
            end
         end
         CAP_GAP:
         begin
            if (cap_fall)
            begin
               if (s.gap_cnt != '0)
                  st_next.gap_cnt = s.gap_cnt - 1'b1;
               else if (s.sent != WORD_BITS_CNT)
               begin
                  st_next.cstate = CAP_SHIFT;
                  st_next.ws = ws_active;
                  do_send = 1'b1;
               end
               else if (fifo_out_valid)
                  do_load = 1'b1;
               else
                  st_next.cstate = CAP_START;
            end
         end
      endcase

      if (do_load)
      begin
         fifo_pop = 1'b1;
         st_next.cstate = CAP_SHIFT;
         st_next.ws = ws_active;
         st_next.sout = fifo_out_data[WORD_BITS-1];
         st_next.shreg = {fifo_out_data[WORD_BITS-2:0], 1'b0};
         st_next.sent = 6'h01;
         st_next.words_left = s.words_left - 1'b1;
      end
      if (do_send)
      begin
         st_next.sout = s.shreg[WORD_BITS-1];
         st_next.shreg = {s.shreg[WORD_BITS-2:0], 1'b0};
         st_next.sent = s.sent + 1'b1;
      end

      // Disabling drops any frame in flight
      if (!cap_on && s.cstate != CAP_IDLE)
      begin
         st_next.cstate = CAP_IDLE;
         st_next.fetch_left = '0;
         st_next.fetch_pend = 1'b0;
         st_next.ws = ~ws_active;
         st_next.sout = 1'b1;
         fifo_clear = 1'b1;
         fifo_pop = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; capture pins high after reset
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         st_reg <= '0;
         st_reg.sclk_s <= 3'h7;
         st_reg.ss_s <= 3'h7;
         st_reg.cstate <= CAP_IDLE;
         st_reg.cclk <= 1'b1;
         st_reg.ws <= 1'b1;
         st_reg.sout <= 1'b1;
      end
      else
         st_reg <= st_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign miso_out = s.miso;
   assign miso_oe = s.miso_oe;
   assign reg_wr_strobe = s.wr_strobe;
   assign reg_wr = s.wr;
   assign reg_rd_req = s.rd_req;
   assign reg_rd_addr = s.cur_addr;
   assign capture_serial_clock = s.cclk;
   assign capture_word_select = s.ws;
   assign capture_serial_out = s.sout;
   assign capture_busy = s.cstate != CAP_IDLE;

endmodule : ssc_port
`default_nettype wire

// ==== src/ssc_sample_mem.sv ====
`timescale 1ns/10ps
`default_nettype none
module ssc_sample_mem
   import ssc_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Write port
   input wire logic wr_en,
   input wire logic [3:0] wr_slot,
   input wire logic [WORD_BITS-1:0] wr_data,
   // Read port
   input wire logic [3:0] rd_slot,
   output logic [WORD_BITS-1:0] rd_data
);

   typedef struct packed {
      logic [NUM_SLOTS-1:0][WORD_BITS-1:0] mem;
      logic [WORD_BITS-1:0] rdata;
   } ssc_mem_st_t;

   ssc_mem_st_t st_reg;
   ssc_mem_st_t st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.rdata = st_reg.mem[rd_slot];
      if (wr_en)
      begin
         st_next.mem[wr_slot] = wr_data;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign rd_data = st_reg.rdata;

endmodule : ssc_sample_mem
`default_nettype wire

// ==== tb/ssc_cap_rx.sv ====
`timescale 1ns/10ps
`default_nettype none
module ssc_cap_rx (
   // Capture pins
   input wire logic sck,
   input wire logic sel,
   input wire logic sdo,
   input wire logic pol,
   // Collected frame
   input wire logic clear,
   output logic [31:0] words [16],
   output int n_words,
   output int gap_rises
);
   int nb, idle;
   // Gap clocks count only when another package follows
   always @(posedge sck or posedge clear)
      if (clear)
         {nb, n_words, gap_rises, idle} = 128'h0;
      else if (sel !== pol || nb > 511)
         idle++;
      else
      begin
         gap_rises += nb > 0 ? idle : 0;
         idle = 0;
         words[nb / 32] = {words[nb / 32][30:0], sdo};
         nb++;
         n_words = nb / 32;
      end
endmodule : ssc_cap_rx
`default_nettype wire

// ==== tb/ssc_port_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module ssc_port_asserts
   import ssc_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Serial slave side
   input wire logic ss_n_pin,
   input wire logic miso_oe,
   input wire logic reg_wr_strobe,
   input wire logic reg_rd_req,
   input wire logic [15:0] reg_rd_addr,
   // Capture side
   input wire logic spi_selected,
   input wire logic [7:0] device_config,
   input wire ssc_cap_cfg_t capture_configuration_reg,
   input wire logic capture_serial_clock,
   input wire logic capture_word_select,
   input wire logic capture_busy
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   miso_idle_a: assert property (ss_n_pin [*5] |-> !miso_oe)
      else $error("data out driven while deselected");
   wr_after_end_a: assert property (reg_wr_strobe |-> ss_n_pin && $past(ss_n_pin, 3))
      else $error("write completed before deselect");
   rd_range_a: assert property (reg_rd_req |-> !ss_n_pin &&
      (reg_rd_addr < BURST_FIRST || reg_rd_addr > BURST_LAST)) else $error("bad single read");
   spi_blocks_a: assert property (spi_selected && !capture_busy |=> !capture_busy)
      else $error("capture started with serial slave active");
   enable_gate_a: assert property (!device_config[CAP_EN_POS] && !capture_busy |=> !capture_busy)
      else $error("capture started while disabled");
   sel_idle_a: assert property ((!capture_busy && $stable(capture_configuration_reg)) [*3]
      |-> capture_word_select == !capture_configuration_reg.select_polarity) else $error("idle select");
   sel_on_fall_a: assert property (capture_busy && $changed(capture_word_select)
      |-> $fell(capture_serial_clock)) else $error("select moved inside a word");
   half_fast_a: assert property ($fell(capture_serial_clock) && !capture_configuration_reg.rate_slow
      |-> ##[6:7] $rose(capture_serial_clock)) else $error("fast capture clock off rate");
endmodule : ssc_port_asserts
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
   import ssc_pkg::*;
   logic clock = 1'b0, rst = 1'b1, sclk_pin = 1'b1, ss_n_pin = 1'b1, mosi_pin = 1'b1;
   logic sample_wr_en = 1'b0, frame_strobe = 1'b0, spi_selected = 1'b0, rx_clear = 1'b0;
   logic miso_out, miso_oe, reg_wr_strobe, reg_rd_req, capture_busy;
   logic capture_serial_clock, capture_word_select, capture_serial_out;
   logic [3:0] sample_wr_slot = 4'h0;
   logic [23:0] sample_wr_value = 24'h000000;
   logic [7:0] device_config = 8'h00;
   ssc_cap_cfg_t capture_configuration_reg = 8'h00;
   ssc_wr_t reg_wr, wr_seen;
   logic [15:0] reg_rd_addr;
   logic [31:0] reg_rd_data, words [16];
   logic [1:0] reg_rd_len = LEN_32;
   int n_mismatch = 0, check_count = 0, n_words, gap_rises, wr_n = 0;
   wire logic miso = miso_oe ? miso_out : 1'bz;
   assign reg_rd_data = {reg_rd_addr, ~reg_rd_addr};
   always #5 clock = ~clock;
   always @(posedge clock)
      if (reg_wr_strobe)
      begin
         wr_seen <= reg_wr;
         wr_n <= wr_n + 1;
      end
   ssc_port ssc_port_inst (.clock, .rst, .sclk_pin, .ss_n_pin, .mosi_pin, .miso_out, .miso_oe,
      .reg_wr_strobe, .reg_wr, .reg_rd_req, .reg_rd_addr, .reg_rd_data, .reg_rd_len,
      .sample_wr_en, .sample_wr_slot, .sample_wr_value, .frame_strobe, .spi_selected,
      .device_config, .capture_configuration_reg, .capture_serial_clock, .capture_word_select,
      .capture_serial_out, .capture_busy);
   ssc_cap_rx ssc_cap_rx_inst (.sck(capture_serial_clock), .sel(capture_word_select),
      .sdo(capture_serial_out), .pol(capture_configuration_reg.select_polarity),
      .clear(rx_clear), .words, .n_words, .gap_rises);
   task automatic t(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : t
   task automatic ck(input logic [95:0] g, input logic [95:0] e);
      check_count++;
      n_mismatch += int'(g !== e);
      if (g !== e)
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
   endtask : ck
   function automatic logic [31:0] ex(input int k);
      logic [23:0] v;
      v = 24'h700000 + 24'(k * 24'h1f2e3d);
      return {{8{v[23]}}, v};
   endfunction : ex
   // Host bit-bang, 80 ns serial clock, idle high
   task automatic spi(input int n, input logic [119:0] d, output logic [95:0] r);
      ss_n_pin = 1'b0;
      t(4);
      for (int i = n - 1; i >= 0; i--)
      begin
         sclk_pin = 1'b0;
         mosi_pin = d[i];
         t(4);
         sclk_pin = 1'b1;
         r = {r[94:0], miso};
         t(4);
      end
      ss_n_pin = 1'b1;
      mosi_pin = ~mosi_pin;
      t(12);
   endtask : spi
   task automatic pulse();
      frame_strobe = 1'b1;
      t(1);
      frame_strobe = 1'b0;
      t(8);
   endtask : pulse
   task automatic t_write();
      logic [95:0] r;
      spi(56, {8'hf0, 16'h1234, 32'hdeadbeef}, r);
      ck(wr_seen, {16'h1234, 32'hdeadbeef, LEN_32});
      spi(32, {8'h02, 16'h0abc, 8'h5a}, r);
      ck(wr_seen, {16'h0abc, 32'h5a, LEN_8});
      spi(36, {8'h00, 16'h0abd, 12'h123}, r);
      ck(wr_n, 2);
   endtask : t_write
   task automatic t_read();
      logic [95:0] r;
      spi(56, {8'hfd, 16'h4380, 32'h0}, r);
      ck(r[31:0], {16'h4380, 16'hbc7f});
      ck(miso, 1'bz);
      spi(120, {8'h01, BURST_FIRST, 96'h0}, r);
      ck(r, {ex(0), ex(1), ex(2)});
      spi(88, {8'h01, 16'he51b, 64'h0}, r);
      ck(r[63:0], {ex(15), 32'h0});
   endtask : t_read
   task automatic t_blocked();
      spi_selected = 1'b1;
      device_config = 8'h40;
      pulse();
      ck(capture_busy, 1'b0);
      spi_selected = 1'b0;
      device_config = 8'h00;
      pulse();
      ck(capture_busy, 1'b0);
   endtask : t_blocked
   task automatic t_cap(input logic [7:0] c, input int first, input int n);
      capture_configuration_reg = c;
      rx_clear = 1'b1;
      t(4);
      rx_clear = 1'b0;
      device_config = 8'h40;
      pulse();
      for (int k = 0; k < 30000 && capture_busy !== 1'b0; k++)
         t(1);
      ck(n_words, n);
      for (int i = 0; i < n; i++)
         ck(words[i], ex(first + i));
      ck(gap_rises, c[2] ? 7 * ((c[1] ? 4 * n : n) - 1) : 0);
      device_config = 8'h00;
   endtask : t_cap
   task automatic finish_test();
      if (n_mismatch == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   initial
   begin
      t(8);
      rst = 1'b0;
      t(4);
      sample_wr_en = 1'b1;
      for (int k = 0; k < 16; k++)
      begin
         sample_wr_slot = 4'(k);
         sample_wr_value = 24'(ex(k));
         t(1);
      end
      sample_wr_en = 1'b0;
      t_write();
      t_read();
      t_blocked();
      t_cap(8'hc8, 0, 7);
      t_cap(8'h35, 7, 9);
      t_cap(8'h18, 0, 16);
      t_cap(8'h06, 0, 16);
      finish_test();
   end
   initial
   begin
      #1ms;
      n_mismatch++;
      finish_test();
   end
endmodule : tb
bind ssc_port ssc_port_asserts ssc_port_asserts_inst (.clock, .rst, .ss_n_pin, .miso_oe,
   .reg_wr_strobe, .reg_rd_req, .reg_rd_addr, .spi_selected, .device_config,
   .capture_configuration_reg, .capture_serial_clock, .capture_word_select, .capture_busy);
`default_nettype wire
